// ==== rtl/xfer_exec.sv ====
// Execution unit for register transfer and RAM address instructions
// Function
// - D register into accumulator bits two-zero
// - Z register into accumulator bits one-zero
// - X register copied whole into accumulator
// - Stack pointer into accumulator bits two-zero
// - XY load writes x and y immediates
// - Consecutive XY loads after first are skipped
// - Z load writes z immediate into Z
// - Y increment; skip next when Y becomes zero
// - Y decrement; skip next when Y becomes fifteen
// - RAM to accumulator, then X xor j
// - Swap accumulator and RAM, X xor j
// - Swap, X xor j, decrement Y, skip
// - Swap, X xor j, increment Y, skip
// - Accumulator to RAM, then X xor j
`timescale 1ns/1ns
module xfer_exec (
  // Clock and reset
  input  wire logic           ref_clk,
  input  wire logic           rst,
  // Instruction from fetch stage, one per exec_en
  input  wire logic           exec_en,
  input  wire xfer_pkg::op_e  op,
  input  wire logic [9:0]     instr,
  // Other CPU state sources
  input  wire logic [2:0]     d_val,
  input  wire logic [2:0]     stack_pointer,
  input  wire logic [3:0]     a_ext,
  input  wire logic           a_ext_we,
  // RAM nibble at the data pointer
  input  wire logic [3:0]     ram_at_data_pointer,
  output logic                ram_we,
  output logic      [3:0]     ram_wdata,
  // Architectural registers
  output logic      [3:0]     acc,
  output logic      [3:0]     x_out,
  output logic      [3:0]     y_out,
  output logic      [1:0]     z_out,
  // Skip status of the next instruction
  output logic                skip_pending
);

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  logic [3:0] a_reg, a_next;
  logic [3:0] x_reg, x_next;
  logic [3:0] y_reg, y_next;
  logic [1:0] z_reg, z_next;
  logic       skip_reg, skip_next;
  logic       last_load_xy_reg;
  logic       ram_we_reg;
  logic [3:0] ram_wdata_reg;

  // ------------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------------
  wire [3:0] imm_j = instr[xfer_pkg::J_LSB +: 4];
  wire [3:0] imm_x = instr[xfer_pkg::X_LSB +: 4];
  wire [3:0] imm_y = instr[xfer_pkg::Y_LSB +: 4];
  wire [1:0] imm_z = instr[xfer_pkg::Z_LSB +: 2];

  // One strobe per operation keeps the selects below flat
  wire op_nop   = (op == xfer_pkg::OP_NOP);
  wire op_tda   = (op == xfer_pkg::OP_TDA);
  wire op_tza   = (op == xfer_pkg::OP_TZA);
  wire op_txa   = (op == xfer_pkg::OP_TXA);
  wire op_tsa   = (op == xfer_pkg::OP_TSA);
  wire op_ld_xy = (op == xfer_pkg::OP_LOAD_XY);
  wire op_lz    = (op == xfer_pkg::OP_LZ);
  wire op_iny   = (op == xfer_pkg::OP_INY);
  wire op_dey   = (op == xfer_pkg::OP_DEY);
  wire op_tam   = (op == xfer_pkg::OP_TAM);
  wire op_xam   = (op == xfer_pkg::OP_XAM);
  wire op_xamd  = (op == xfer_pkg::OP_XAMD);
  wire op_xami  = (op == xfer_pkg::OP_XAMI);
  wire op_tma   = (op == xfer_pkg::OP_TMA);

  wire is_load_xy  = op_ld_xy;
  wire load_xy_run = is_load_xy && last_load_xy_reg;
  // Skipped slots still pass through and commit nothing, except a_ext into A in a repeated XY load slot
  wire live    = exec_en && !skip_reg && !load_xy_run;
  wire is_dec  = op_dey || op_xamd;
  wire is_y    = is_dec || op_iny || op_xami;
  wire is_xj   = op_tam || op_xam || op_xamd || op_xami || op_tma;
  wire is_swap = op_xam || op_xamd || op_xami;
  wire is_wr   = is_swap || op_tma;
  // Write strobe lands with the new accumulator, one edge later
  wire ram_we_next = live && is_wr;

  wire [3:0] y_stepped;
  wire       y_wrap;

  y_step u_y_step (
    .y_in    (y_reg),
    .down    (is_dec),
    .y_out   (y_stepped),
    .wrapped (y_wrap)
  );

  // ------------------------------------------------------------------
  // Next-state selection
  // ------------------------------------------------------------------
  always_comb begin
    a_next    = a_reg;
    x_next    = x_reg;
    y_next    = y_reg;
    z_next    = z_reg;
    skip_next = 1'b0;
    if (live) begin
      unique case (op)
        xfer_pkg::OP_TDA: a_next = {1'b0, d_val};
        xfer_pkg::OP_TZA: a_next = {2'b00, z_reg};
        xfer_pkg::OP_TXA: a_next = x_reg;
        xfer_pkg::OP_TSA: a_next = {1'b0, stack_pointer};
        xfer_pkg::OP_LOAD_XY: begin
          x_next = imm_x;
          y_next = imm_y;
        end
        xfer_pkg::OP_LZ:  z_next = imm_z;
        xfer_pkg::OP_TAM: a_next = ram_at_data_pointer;
        xfer_pkg::OP_XAM,
        xfer_pkg::OP_XAMD,
        xfer_pkg::OP_XAMI: a_next = ram_at_data_pointer;
        default: a_next = a_reg;
      endcase
      if (is_xj)
        x_next = x_reg ^ imm_j;
      if (is_y) begin
        y_next    = y_stepped;
        skip_next = y_wrap;
      end
    end else if (exec_en && !skip_reg && a_ext_we) begin
      a_next = a_ext;
    end
    // Other units may load A in an unskipped empty slot or in a repeated XY load slot
    if (live && a_ext_we && op_nop)
      a_next = a_ext;
  end

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      a_reg <= xfer_pkg::A_RST;
    end else begin
      a_reg <= a_next;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      x_reg <= xfer_pkg::X_RST;
    end else begin
      x_reg <= x_next;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      y_reg <= xfer_pkg::Y_RST;
    end else begin
      y_reg <= y_next;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      z_reg <= xfer_pkg::Z_RST;
    end else begin
      z_reg <= z_next;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      skip_reg <= 1'b0;
    end else if (exec_en) begin
      skip_reg <= skip_next;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      last_load_xy_reg <= 1'b0;
    end else if (exec_en) begin
      last_load_xy_reg <= is_load_xy;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ram_we_reg <= 1'b0;
    end else begin
      ram_we_reg <= ram_we_next;
    end
  end

  // Old accumulator goes to RAM on both swap and store
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ram_wdata_reg <= 4'h0;
    end else begin
      ram_wdata_reg <= a_reg;
    end
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  assign acc          = a_reg;
  assign x_out        = x_reg;
  assign y_out        = y_reg;
  assign z_out        = z_reg;
  assign skip_pending = skip_reg;
  assign ram_we       = ram_we_reg;
  assign ram_wdata    = ram_wdata_reg;

endmodule

// ==== include/xfer_pkg.sv ====
// Package: opcodes, field positions and reset values for the transfer unit
package xfer_pkg;

  // ------------------------------------------------------------------
  // Instruction word layout (10-bit)
  // ------------------------------------------------------------------
  localparam int IW = 10;

  // Operation selector presented by the fetch stage
  typedef enum logic [3:0] {
    OP_NOP,
    OP_TDA,    // D  -> A[2:0]
    OP_TZA,    // Z  -> A[1:0]
    OP_TXA,    // X  -> A
    OP_TSA,    // stack pointer -> A[2:0]
    OP_LOAD_XY,    // x,y immediates -> X,Y
    OP_LZ,     // z immediate -> Z
    OP_INY,
    OP_DEY,
    OP_TAM,    // RAM -> A, X ^= j
    OP_XAM,    // swap, X ^= j
    OP_XAMD,   // swap, X ^= j, Y--
    OP_XAMI,   // swap, X ^= j, Y++
    OP_TMA     // A -> RAM, X ^= j
  } op_e;

  // Immediate field positions within the instruction word
  localparam int J_LSB  = 0;
  localparam int Y_LSB  = 0;
  localparam int X_LSB  = 4;
  localparam int Z_LSB  = 0;

  // Reset values
  localparam logic [3:0] A_RST = 4'h0;
  localparam logic [3:0] X_RST = 4'h0;
  localparam logic [3:0] Y_RST = 4'h0;
  localparam logic [1:0] Z_RST = 2'h0;

  // Wrap values that trigger a skip
  localparam logic [3:0] Y_INC_WRAP = 4'h0;
  localparam logic [3:0] Y_DEC_WRAP = 4'hF;

endpackage

// ==== rtl/y_step.sv ====
// Y counter step unit with wrap detection for the skip decision
`timescale 1ns/1ns
module y_step (
  // Operand
  input  wire logic [3:0] y_in,
  input  wire logic       down,
  // Result
  output logic      [3:0] y_out,
  output logic            wrapped
);

  assign y_out   = down ? 4'(y_in - 4'h1) : 4'(y_in + 4'h1);
  assign wrapped = down ? (y_out == xfer_pkg::Y_DEC_WRAP)
                        : (y_out == xfer_pkg::Y_INC_WRAP);

endmodule

// ==== testbench/xfer_exec_sva.sv ====
// Checker for the transfer execution unit
`timescale 1ns/1ns
module xfer_exec_sva (
  // Clock and slot
  input wire logic          ref_clk,
  input wire logic          rst,
  input wire logic          exec_en,
  input wire xfer_pkg::op_e op,
  input wire logic [9:0]    instr,
  input wire logic [2:0]    d_val,
  input wire logic [3:0]    ram_at_data_pointer,
  // Results
  input wire logic          ram_we,
  input wire logic [3:0]    ram_wdata,
  input wire logic [3:0]    acc,
  input wire logic [3:0]    x_out,
  input wire logic [3:0]    y_out,
  input wire logic [1:0]    z_out,
  input wire logic          skip_pending
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  wire live = exec_en && !skip_pending;
  wire xy_op = exec_en && op == xfer_pkg::OP_LOAD_XY;
  chk_d_to_acc: assert property (live && op == xfer_pkg::OP_TDA
    |=> acc[2:0] == $past(d_val)) else $error("d move wrong");
  chk_x_to_acc: assert property (live && op == xfer_pkg::OP_TXA
    |=> acc == $past(x_out)) else $error("x move wrong");
  chk_xy_run: assert property (xy_op ##1 xy_op
    |=> $stable(x_out) && $stable(y_out)) else $error("xy run ran");
  chk_z_load: assert property (live && op == xfer_pkg::OP_LZ
    |=> z_out == $past(instr[1:0])) else $error("z load wrong");
  chk_inc_skip: assert property (live && op == xfer_pkg::OP_INY
    |=> y_out == $past(y_out) + 4'h1 && skip_pending == (y_out == 4'h0))
    else $error("inc wrong");
  chk_dec_skip: assert property (live && op == xfer_pkg::OP_DEY
    |=> y_out == $past(y_out) - 4'h1 && skip_pending == (y_out == 4'hF))
    else $error("dec wrong");
  chk_ram_read: assert property (live && op == xfer_pkg::OP_TAM
    |=> acc == $past(ram_at_data_pointer)
    && x_out == ($past(x_out) ^ $past(instr[3:0]))) else $error("read bad");
  chk_ram_write: assert property (live && op == xfer_pkg::OP_TMA
    |=> ram_we && ram_wdata == $past(acc)) else $error("write bad");
  chk_skip_quiet: assert property (exec_en && skip_pending
    |=> !ram_we && !skip_pending && $stable(acc) && $stable(x_out))
    else $error("skipped slot acted");
endmodule
bind xfer_exec xfer_exec_sva chk (.ref_clk, .rst, .exec_en, .op, .instr,
  .d_val, .ram_at_data_pointer, .ram_we, .ram_wdata, .acc, .x_out, .y_out,
  .z_out, .skip_pending);

// ==== testbench/tb.sv ====
// Self-checking bench for the transfer execution unit
`timescale 1ns/1ns
module tb;
  localparam xfer_pkg::op_e XY = xfer_pkg::OP_LOAD_XY;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic exec_en = 1'b0;
  xfer_pkg::op_e op = xfer_pkg::OP_NOP;
  logic [9:0] instr = 10'h000;
  logic [2:0] d_val = 3'h0;
  logic [2:0] stack_pointer = 3'h0;
  logic [3:0] ram = 4'h0;
  logic ram_we, skip_pending, ms, px, sk, we, up, dn;
  logic [3:0] ram_wdata, acc, x_out, y_out, ma, mx, my, wd;
  logic [1:0] z_out, mz;
  logic [19:0] expq[$];
  int fails = 0;
  int num_checks = 0;
  int cycles = 0;
  always #5 ref_clk = ~ref_clk;
  xfer_exec dut (.ref_clk, .rst, .exec_en, .op, .instr, .d_val,
    .stack_pointer, .a_ext(4'h0), .a_ext_we(1'b0), .ram_at_data_pointer(ram),
    .ram_we, .ram_wdata, .acc, .x_out, .y_out, .z_out, .skip_pending);
  task automatic close_out();
    if (fails == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic check_state(input logic [19:0] e, input logic [19:0] g);
    num_checks++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  // ------------------------------------------------------------------
  // Driver with reference model
  // ------------------------------------------------------------------
  task automatic slot(input logic [3:0] o, input logic [9:0] i, input bit en);
    @(negedge ref_clk);
    exec_en = en;
    op = xfer_pkg::op_e'(o);
    instr = i;
    d_val = 3'($urandom);
    stack_pointer = 3'($urandom);
    ram = 4'($urandom);
    if (en) begin
      sk = ms || (op == XY && px);
      px = (op == XY);
      ms = 1'b0;
      we = 1'b0;
      up = op inside {xfer_pkg::OP_INY, xfer_pkg::OP_XAMI};
      dn = op inside {xfer_pkg::OP_DEY, xfer_pkg::OP_XAMD};
      if (!sk) begin
        case (op)
          xfer_pkg::OP_TDA: ma = {1'b0, d_val};
          xfer_pkg::OP_TZA: ma = {2'b00, mz};
          xfer_pkg::OP_TXA: ma = mx;
          xfer_pkg::OP_TSA: ma = {1'b0, stack_pointer};
          XY: {mx, my} = i[7:0];
          xfer_pkg::OP_LZ: mz = i[1:0];
          xfer_pkg::OP_NOP: ;
          default: begin
            my = my + {3'h0, up} - {3'h0, dn};
            ms = (up && my == 4'h0) || (dn && my == 4'hF);
            if (op >= xfer_pkg::OP_TAM && op <= xfer_pkg::OP_TMA) begin
              mx = mx ^ i[3:0];
              we = op != xfer_pkg::OP_TAM;
              wd = ma;
              ma = (op == xfer_pkg::OP_TMA) ? ma : ram;
            end
          end
        endcase
      end
      expq.push_back({ma, mx, my, mz, ms, we, we ? wd : 4'h0});
    end
  endtask
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles > 3000) begin
      fails++;
      close_out();
    end
    if (exec_en && !rst) begin
      #1;
      check_state(expq.pop_front(), {acc, x_out, y_out, z_out, skip_pending,
        ram_we, ram_we ? ram_wdata : 4'h0});
    end
  end
  initial begin
    void'($urandom(74605));
    {ma, mx, my, wd, mz, ms, px} = '0;
    repeat (4) @(posedge ref_clk);
    @(negedge ref_clk);
    rst = 1'b0;
    foreach (expq[k]) expq.delete();
    slot(4'h5, 10'h0A3, 1'b1);
    slot(4'h5, 10'h012, 1'b1);
    slot(4'h5, 10'h0FF, 1'b1);
    slot(4'h7, 10'h000, 1'b1);
    slot(4'h3, 10'h000, 1'b1);
    slot(4'h8, 10'h000, 1'b1);
    slot(4'hE, 10'h3C5, 1'b1);
    repeat (1500) slot(4'($urandom_range(13, 0)), 10'($urandom),
      $urandom_range(3, 0) != 0);
    slot(4'h0, 10'h000, 1'b0);
    repeat (2) @(posedge ref_clk);
    close_out();
  end
endmodule
